//--- design/pg_pkg.sv
// constants and carrier types for the legacy fast-control and gate block
`default_nettype none
package pg_pkg;
  // host side addressing
  localparam logic [15:0] IO_FAST_CTRL_ADDR = 16'h0092;
  localparam logic [7:0] CFG_LDN = 8'h01;
  localparam logic [7:0] CFG_ENABLE_INDEX = 8'h30;
  // firmware side addressing
  localparam logic [31:0] EC_CFG_BASE = 32'h000f_1800;
  localparam logic [31:0] EC_ONLY_BASE = 32'h000f_1900;
  localparam logic [31:0] OFS_ENABLE = 32'h0000_0030;
  localparam logic [31:0] OFS_FAST_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_GATE_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_GATE_SET = 32'h0000_0008;
  localparam logic [31:0] OFS_GATE_CLR = 32'h0000_000c;
  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int FAST_RESET_BIT = 0;
  localparam int ALT_GATE_BIT = 1;
  localparam int GATE_BIT = 0;
  // reset values
  localparam logic RST_ENABLE = 1'h0;
  localparam logic [1:0] RST_FAST_CTRL = 2'h0;
  localparam logic RST_GATE = 1'h0;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_DELAY_NS = 14000;
  localparam int RESET_PULSE_NS = 6000;
  localparam int DELAY_CYC = (RESET_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
    RESET_DELAY_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_DELAY = 3'b010,
    PG_PULSE = 3'b100
  } pg_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pg_io_req_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] logical_device_number;
    logic [7:0] index;
    logic [7:0] wdata;
  } pg_cfg_req_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [7:0] wdata;
  } pg_ec_req_type;
endpackage
`default_nettype wire

//--- design/pg_legacy_gate.sv
// legacy fast-control port, address-line gate and fast cpu reset pulse
`default_nettype none
module pg_legacy_gate
  import pg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic io_block_reset_n,
  input wire logic main_power_good,
  input wire pg_io_req_type host_io,
  output logic [7:0] host_rdata,
  input wire pg_cfg_req_type host_cfg,
  output logic [7:0] cfg_rdata,
  input wire pg_ec_req_type ec_req,
  output logic [7:0] ec_rdata,
  output logic alternate_gate_signal,
  output logic address_line_gate,
  output logic fast_reset_pulse_n
);

  ////////////////////////////////////////////////////////////////////////////
  // reset pins come from other domains: two flops before use
  logic [1:0] io_rst_sync_q;
  logic [1:0] pg_sync_q;
  logic io_rst_n;
  logic pwr_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_rst_sync_q <= 2'h0;
      pg_sync_q <= 2'h0;
    end else begin
      io_rst_sync_q <= {io_rst_sync_q[0], io_block_reset_n};
      pg_sync_q <= {pg_sync_q[0], main_power_good};
    end
  end
  assign io_rst_n = io_rst_sync_q[1];
  assign pwr_ok = pg_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic io_hit;
  logic cfg_hit;
  logic ec_en_hit;
  logic ec_fc_hit;
  logic ec_gate_hit;
  logic ec_set_hit;
  logic ec_clr_hit;
  logic fc_wr;

  assign io_hit = (host_io.addr == IO_FAST_CTRL_ADDR);
  assign cfg_hit = (host_cfg.logical_device_number == CFG_LDN) && (host_cfg.index == CFG_ENABLE_INDEX);
  assign ec_en_hit = (ec_req.addr == EC_CFG_BASE + OFS_ENABLE);
  assign ec_fc_hit = (ec_req.addr == EC_CFG_BASE + OFS_FAST_CTRL);
  assign ec_gate_hit = (ec_req.addr == EC_ONLY_BASE + OFS_GATE_CTRL);
  assign ec_set_hit = (ec_req.addr == EC_ONLY_BASE + OFS_GATE_SET);
  assign ec_clr_hit = (ec_req.addr == EC_ONLY_BASE + OFS_GATE_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // enable register, cleared by system reset or loss of main power
  logic legacy_port_enable_bit_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      legacy_port_enable_bit_q <= RST_ENABLE;
    end else if (!pwr_ok) begin
      legacy_port_enable_bit_q <= RST_ENABLE;
    end else if (host_cfg.wr && cfg_hit) begin
      legacy_port_enable_bit_q <= host_cfg.wdata[ENABLE_BIT];
    end else if (ec_req.wr && ec_en_hit) begin
      legacy_port_enable_bit_q <= ec_req.wdata[ENABLE_BIT];
    end
  end

  // host 92h write only counts while the port is enabled
  assign fc_wr = host_io.wr && io_hit && legacy_port_enable_bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // fast-control register, cleared by the io block reset
  logic alternate_gate_bit_q;
  logic fast_cpu_reset_bit_q;
  logic trig;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {alternate_gate_bit_q, fast_cpu_reset_bit_q} <= RST_FAST_CTRL;
    end else if (!io_rst_n) begin
      {alternate_gate_bit_q, fast_cpu_reset_bit_q} <= RST_FAST_CTRL;
    end else if (fc_wr) begin
      alternate_gate_bit_q <= host_io.wdata[ALT_GATE_BIT];
      fast_cpu_reset_bit_q <= host_io.wdata[FAST_RESET_BIT];
    end
  end
  assign alternate_gate_signal = alternate_gate_bit_q;

  // only a 0 to 1 change arms a pulse; rewriting 1 does nothing
  assign trig = fc_wr && host_io.wdata[FAST_RESET_BIT] && !fast_cpu_reset_bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // firmware gate control with set and clear strobes
  logic gate_bit_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_bit_q <= RST_GATE;
    end else if (ec_req.wr && ec_set_hit) begin
      gate_bit_q <= 1'h1;
    end else if (ec_req.wr && ec_clr_hit) begin
      gate_bit_q <= 1'h0;
    end else if (ec_req.wr && ec_gate_hit) begin
      gate_bit_q <= ec_req.wdata[GATE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      address_line_gate <= 1'h0;
    end else begin
      address_line_gate <= alternate_gate_bit_q | gate_bit_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast reset sequencer
  pg_state_type state_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PG_IDLE;
      cnt_q <= '0;
      fast_reset_pulse_n <= 1'h1;
    end else if (!io_rst_n) begin
      state_q <= PG_IDLE;
      cnt_q <= '0;
      fast_reset_pulse_n <= 1'h1;
    end else begin
      case (state_q)
        PG_IDLE: begin
          cnt_q <= '0;
          // a request during a running sequence is dropped, not queued
          if (trig) begin
            state_q <= PG_DELAY;
          end
        end
        PG_DELAY: begin
          if (cnt_q == CNT_W'(DELAY_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= PG_PULSE;
            fast_reset_pulse_n <= 1'h0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PG_PULSE: begin
          if (cnt_q == CNT_W'(PULSE_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= PG_IDLE;
            fast_reset_pulse_n <= 1'h1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= PG_IDLE;
          cnt_q <= '0;
          fast_reset_pulse_n <= 1'h1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= 8'h00;
      cfg_rdata <= 8'h00;
      ec_rdata <= 8'h00;
    end else begin
      if (host_io.rd && io_hit && legacy_port_enable_bit_q) begin
        host_rdata <= {6'h00, alternate_gate_bit_q, fast_cpu_reset_bit_q};
      end else begin
        host_rdata <= 8'h00;
      end
      if (host_cfg.rd && cfg_hit) begin
        cfg_rdata <= {7'h00, legacy_port_enable_bit_q};
      end else begin
        cfg_rdata <= 8'h00;
      end
      if (ec_req.rd && ec_en_hit) begin
        ec_rdata <= {7'h00, legacy_port_enable_bit_q};
      end else if (ec_req.rd && ec_fc_hit) begin
        ec_rdata <= {6'h00, alternate_gate_bit_q, fast_cpu_reset_bit_q};
      end else if (ec_req.rd && ec_gate_hit) begin
        ec_rdata <= {7'h00, gate_bit_q};
      end else begin
        ec_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CNT_W-1:0] low_cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= '0;
    end else if (!fast_reset_pulse_n) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end else begin
      low_cnt_q <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_armed;
    trig && io_rst_n && (state_q == PG_IDLE);
  endsequence

  sequence s_counting;
    (state_q == PG_DELAY) && fast_reset_pulse_n;
  endsequence

  a_disabled_write_drop: assert property (
    (host_io.wr && io_hit && !legacy_port_enable_bit_q && io_rst_n)
      |=> $stable(alternate_gate_bit_q) && $stable(fast_cpu_reset_bit_q))
    else $error("write to 92h changed register while disabled");

  a_alt_gate_write: assert property (
    (fc_wr && io_rst_n) |=> alternate_gate_signal == $past(host_io.wdata[ALT_GATE_BIT]))
    else $error("alternate gate signal did not follow write");

  a_gate_low_cause: assert property (
    !address_line_gate |-> !$past(alternate_gate_bit_q) && !$past(gate_bit_q))
    else $error("gate output low while a source was high");

  a_gate_alt_high: assert property (
    alternate_gate_signal |=> address_line_gate)
    else $error("gate output not forced high by alternate gate");

  a_pulse_start: assert property (
    s_armed |=> s_counting [*8])
    else $error("delay phase did not start after reset bit write");

  a_pulse_delay: assert property (
    $fell(fast_reset_pulse_n) |->
      ($past(state_q) == PG_DELAY) && ($past(cnt_q) == CNT_W'(DELAY_CYC - 1)))
    else $error("reset pulse began before the delay elapsed");

  a_pulse_width: assert property (
    // low_cnt_q reaches the full width on the edge that raises the line
    ($rose(fast_reset_pulse_n) && $past(io_rst_n)) |-> low_cnt_q == CNT_W'(PULSE_CYC))
    else $error("reset pulse width wrong");

  a_no_retrigger: assert property (
    (state_q == PG_IDLE && fc_wr && fast_cpu_reset_bit_q) |=> state_q == PG_IDLE)
    else $error("pulse started without a 0 to 1 change");

  a_set_strobe: assert property (
    (ec_req.wr && ec_set_hit) |=> gate_bit_q ##1 address_line_gate)
    else $error("set strobe did not raise gate");

  a_cfg_enable: assert property (
    (host_cfg.wr && cfg_hit && pwr_ok) |=> legacy_port_enable_bit_q == $past(host_cfg.wdata[0]))
    else $error("enable not written via logical device and index");

endmodule // pg_legacy_gate
`default_nettype wire

//--- verif/pg_host_model.sv
// partner model: host chipset and firmware request drivers
`default_nettype none
module pg_host_model
  import pg_pkg::*;
(
  input wire logic clk,
  output var pg_io_req_type host_io,
  output var pg_cfg_req_type host_cfg,
  output var pg_ec_req_type ec_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_io = '0;
    host_cfg = '0;
    ec_req = '0;
  end
  // one-cycle strobe; fields scrambled after release so a stale decode cannot pass
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    host_io = '{w, !w, a, d};
    @(negedge clk);
    host_io = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // device number and index are presented together with the access
  task automatic cfg(input logic w, input logic [7:0] l, input logic [7:0] i,
                     input logic [7:0] d);
    @(negedge clk);
    host_cfg = '{w, !w, l, i, d};
    @(negedge clk);
    host_cfg = '{1'b0, 1'b0, ~l, ~i, ~d};
  endtask
  task automatic ec(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge clk);
    ec_req = '{w, !w, a, d};
    @(negedge clk);
    ec_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // pg_host_model
`default_nettype wire

//--- verif/legacy_port92_gate_a20_bench.sv
// self-checking bench for the legacy fast-control and gate block
`default_nettype none
module legacy_port92_gate_a20_bench
  import pg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, io_block_reset_n, main_power_good;
  pg_io_req_type host_io;
  pg_cfg_req_type host_cfg;
  pg_ec_req_type ec_req;
  logic [7:0] host_rdata, cfg_rdata, ec_rdata;
  logic alternate_gate_signal, address_line_gate, fast_reset_pulse_n;
  logic [7:0] exp_q[$];
  logic [2:0] sel = 3'h0;
  logic [31:0] n, rnd;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  pg_host_model u_host (.clk(clk), .host_io(host_io), .host_cfg(host_cfg), .ec_req(ec_req));
  pg_legacy_gate u_dut (.clk(clk), .resetn(resetn), .io_block_reset_n(io_block_reset_n),
    .main_power_good(main_power_good), .host_io(host_io), .host_rdata(host_rdata),
    .host_cfg(host_cfg), .cfg_rdata(cfg_rdata), .ec_req(ec_req), .ec_rdata(ec_rdata),
    .alternate_gate_signal(alternate_gate_signal), .address_line_gate(address_line_gate),
    .fast_reset_pulse_n(fast_reset_pulse_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic rd_cfg(input logic [7:0] e);
    exp_q.push_back(e);
    u_host.cfg(1'b0, CFG_LDN, CFG_ENABLE_INDEX, 8'h00);
  endtask
  task automatic rd_ec(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.ec(1'b0, a, 8'h00);
  endtask
  task automatic fast(input logic [7:0] d);
    u_host.io(1'b1, IO_FAST_CTRL_ADDR, d);
    @(negedge clk);
  endtask
  task automatic gate_wr(input logic [31:0] o, input logic [7:0] d);
    u_host.ec(1'b1, EC_ONLY_BASE + o, d);
  endtask
  // counts cycles while the pulse line stays at level lv
  task automatic span(input logic lv, input logic [31:0] lim);
    n = 0;
    while (fast_reset_pulse_n === lv && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // rdata is registered, so the oldest note is due one edge after the read
  always @(posedge clk) sel <= {host_io.rd, host_cfg.rd, ec_req.rd};
  always @(negedge clk) begin
    if (sel != 3'h0) begin
      check(sel[2] ? host_rdata : sel[1] ? cfg_rdata : ec_rdata, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(49123));
    resetn = 1'b0;
    io_block_reset_n = 1'b0;
    main_power_good = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    io_block_reset_n = 1'b1;
    main_power_good = 1'b1;
    repeat (3) @(negedge clk);
    rd_cfg(8'h00);
    rd_ec(EC_ONLY_BASE + OFS_GATE_CTRL, 8'h00);
    fast(8'h02);
    check(alternate_gate_signal, 1'b0);
    u_host.cfg(1'b1, 8'h02, CFG_ENABLE_INDEX, 8'h01);
    u_host.cfg(1'b1, CFG_LDN, 8'h31, 8'h01);
    rd_cfg(8'h00);
    u_host.cfg(1'b1, CFG_LDN, CFG_ENABLE_INDEX, 8'hff);
    rd_ec(EC_CFG_BASE + OFS_ENABLE, 8'h01);
    rnd = $urandom;
    fast({rnd[7:2], 2'b10});
    check(alternate_gate_signal, 1'b1);
    exp_q.push_back(8'h02);
    u_host.io(1'b0, IO_FAST_CTRL_ADDR, 8'h00);
    rd_ec(EC_CFG_BASE + OFS_FAST_CTRL, 8'h02);
    gate_wr(OFS_GATE_CTRL, 8'h00);
    @(negedge clk);
    check(address_line_gate, 1'b1);
    fast(8'h00);
    check(address_line_gate, 1'b0);
    gate_wr(OFS_GATE_CTRL, 8'h01);
    @(negedge clk);
    check(address_line_gate, 1'b1);
    gate_wr(OFS_GATE_CTRL, 8'h00);
    @(negedge clk);
    check(address_line_gate, 1'b0);
    gate_wr(OFS_GATE_SET, rnd[15:8]);
    @(negedge clk);
    check(address_line_gate, 1'b1);
    rd_ec(EC_ONLY_BASE + OFS_GATE_CTRL, 8'h01);
    gate_wr(OFS_GATE_CLR, 8'h5a);
    rd_ec(EC_ONLY_BASE + 32'h4, 8'h00);
    fast(8'h01);
    span(1'b1, 32'd1000);
    // fast() returns a cycle and a half after the write edge, so one delay cycle is already gone
    check(n, DELAY_CYC - 1);
    span(1'b0, 32'd1000);
    check(n, PULSE_CYC);
    fast(8'h01);
    span(1'b1, 32'd1100);
    check(n, 32'd1100);
    fast(8'h00);
    fast(8'h01);
    span(1'b1, 32'd1000);
    check(n, DELAY_CYC - 1);
    // abort a running sequence from the io-block reset
    fast(8'h02);
    io_block_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    io_block_reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check(fast_reset_pulse_n, 1'b1);
    rd_ec(EC_CFG_BASE + OFS_FAST_CTRL, 8'h00);
    main_power_good = 1'b0;
    repeat (4) @(negedge clk);
    main_power_good = 1'b1;
    repeat (3) @(negedge clk);
    rd_cfg(8'h00);
    repeat (3) @(negedge clk);
    final_report();
  end
endmodule // legacy_port92_gate_a20_bench
`default_nettype wire
